//--- verilog/hmp_pkg.sv
package hmp_pkg;
  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 4;
  localparam int MASTER_RESET_N_MIN_NS = 500;
  localparam int MASTER_RESET_N_MIN_CYC_I = (MASTER_RESET_N_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = 20;
  localparam int GAP_CYC_I = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths and derived counts
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] MASTER_RESET_N_MIN_CYC = CNT_W'(MASTER_RESET_N_MIN_CYC_I);
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(STROBE_CYC_I);
  localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(GAP_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int HOST_ADDR_W = 4;
  localparam int TADDR_W = 5;
  localparam int MODE_W = 8;

  // Register indices on host address lines 0..3
  localparam logic [HOST_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [HOST_ADDR_W-1:0] REG_STAT = 4'h1;
  localparam logic [HOST_ADDR_W-1:0] REG_TADDR = 4'h2;

  // Control register fields
  localparam int CTRL_ROLE_BIT = 0;
  localparam int CTRL_PDP_BIT = 1;
  localparam int CTRL_MODE_LSB = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  // Status register fields
  localparam int STAT_ROLE_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_OVR_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_PAR_BIT = 4;

  // Terminal address register fields
  localparam int TADDR_PAR_BIT = 5;
  localparam int TADDR_OK_BIT = 6;
  localparam logic [TADDR_W-1:0] TADDR_RESET = 5'h1f;

  // Synchroniser idle values: {cs,rd,wr,aen,role,lock,ovr,master_reset_n,ram_select_in_n,grant,par,taddr,addr,data}
  localparam int SYNC_W = 36;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 36'hffbf00000;

  // Own memory access sequencer
  typedef enum logic [1:0] {
    HMP_IDLE = 2'b00,
    HMP_REQ = 2'b01,
    HMP_STRB = 2'b11,
    HMP_GAP = 2'b10
  } hmp_state_type;
endpackage

//--- verilog/hmp_sync.sv
`timescale 1ns/100ps
module hmp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_i, // System clock
  input wire logic reset_i, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] async_i, // Pin levels
  output logic [WIDTH-1:0] sync_o // Levels in the clock domain
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // Two flops per bit; first stage feeds only the second
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule

//--- verilog/hmp_host_memory_port.sv
// Behaviour
// - Buses float whenever no transfer drives them
// - Sixteen-bit address bus, bit 0 least significant
// - Address 0-3 two-way, 4-15 output only
// - Sixteen-bit two-way data bus
// - Capture terminal address at master reset, readable
// - Parity pin is odd parity over address
// - Chip select plus read returns register contents
// - Chip select plus write stores data bus
// - Drive address only while address enable high
// - Control role bit overrides pin unless locked
// - Lock blocks address, role and mode changes
// - External override aborts own memory access at once
// - Master reset held 500ns clears control register and sequencer
// - Pseudo-dual-port passes RAM select straight through
// - Own memory accesses assert RAM select output
// - Host reads RAM through device in pseudo-dual-port
// - Own reads strobe after grant, once per word
// - Own writes strobe after grant, once per word
`timescale 1ns/100ps
module hmp_host_memory_port
  import hmp_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 250 MHz
  input wire logic reset_i, // Asynchronous reset, active high
  input wire logic [hmp_pkg::HOST_ADDR_W-1:0] addr_i, // Host address lines 0..3
  output logic [hmp_pkg::ADDR_W-1:0] addr_o, // Address bus out
  output logic addr_oe_o, // Address bus drive enable
  input wire logic [hmp_pkg::DATA_W-1:0] data_i, // Data bus in
  output logic [hmp_pkg::DATA_W-1:0] data_o, // Data bus out
  output logic data_oe_o, // Data bus drive enable
  input wire logic cs_n_i, // Chip select, low
  input wire logic rd_n_i, // Read strobe, low
  input wire logic wr_n_i, // Write strobe, low
  input wire logic addr_drive_enable_i, // Host allows address drive
  input wire logic [hmp_pkg::TADDR_W-1:0] term_addr_i, // Terminal address pins
  input wire logic term_addr_parity_i, // Odd parity pin
  input wire logic role_select_pin_i, // Role select pin
  input wire logic lock_i, // Lock pin, high
  input wire logic external_override_n_i, // Override, low
  input wire logic master_reset_n_i, // Master reset, low
  input wire logic ram_select_in_n_i, // Host RAM select, low
  output logic ram_select_out_n_o, // RAM select out, low
  output logic ram_read_strobe_n_o, // RAM read strobe, low
  output logic ram_write_strobe_n_o, // RAM write strobe, low
  input wire logic dma_grant_i, // Memory grant, high
  output logic dma_request_o, // Memory request, high
  input wire logic xfer_start_i, // Start own burst, pulse
  input wire logic xfer_write_i, // Burst direction, high is write
  input wire logic [hmp_pkg::ADDR_W-1:0] xfer_addr_i, // Burst start address
  input wire logic [hmp_pkg::CNT_W-1:0] xfer_count_i, // Burst word count
  input wire logic [hmp_pkg::DATA_W-1:0] xfer_wdata_i, // Current write word
  output logic xfer_wnext_o, // Write word used, pulse
  output logic [hmp_pkg::DATA_W-1:0] xfer_rdata_o, // Read word
  output logic xfer_rvalid_o, // Read word valid, pulse
  output logic xfer_done_o, // Burst finished, pulse
  output logic xfer_abort_o, // Burst aborted, pulse
  output logic xfer_busy_o, // Burst in progress
  output logic role_bc_o, // Effective role, high is controller
  output logic [hmp_pkg::MODE_W-1:0] op_mode_o, // Operation mode selects
  output logic pdp_mode_o, // Pseudo-dual-port mode
  output logic [hmp_pkg::TADDR_W-1:0] term_addr_o, // Captured terminal address
  output logic term_parity_ok_o, // Terminal parity good
  output logic override_active_o, // Override asserted
  output logic master_reset_active_o // Master reset in effect
);
  import hmp_pkg::*;

  logic [SYNC_W-1:0] sync_q;
  logic s_cs_n, s_rd_n, s_wr_n, s_aen, s_role, s_lock, s_ovr_n, s_master_reset_n_n;
  logic s_ram_select_in_n_n, s_grant, s_par;
  logic [TADDR_W-1:0] s_taddr;
  logic [HOST_ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;

  // All pins pass two flops before use
  hmp_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({cs_n_i, rd_n_i, wr_n_i, addr_drive_enable_i, role_select_pin_i, lock_i,
              external_override_n_i, master_reset_n_i, ram_select_in_n_i, dma_grant_i,
              term_addr_parity_i, term_addr_i, addr_i, data_i}),
    .sync_o(sync_q)
  );

  assign {s_cs_n, s_rd_n, s_wr_n, s_aen, s_role, s_lock, s_ovr_n, s_master_reset_n_n,
          s_ram_select_in_n_n, s_grant, s_par, s_taddr, s_addr, s_data} = sync_q;

  // Master reset qualification and terminal address capture
  logic [CNT_W-1:0] master_reset_n_cnt, next_master_reset_n_cnt;
  logic boot, next_boot;
  logic [TADDR_W-1:0] taddr, next_taddr;
  logic tpar, next_tpar;
  logic soft_rst, capture;

  assign soft_rst = (master_reset_n_cnt == MASTER_RESET_N_MIN_CYC) && !s_master_reset_n_n;
  assign capture = boot || ((master_reset_n_cnt == MASTER_RESET_N_MIN_CYC) && s_master_reset_n_n);

  // Host register write detection
  logic wr_act, wr_act_q, next_wr_act_q, wr_commit;
  logic [HOST_ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [DATA_W-1:0] wr_data, next_wr_data;
  logic [DATA_W-1:0] ctrl, next_ctrl;

  assign wr_act = !s_cs_n && !s_wr_n;
  assign wr_commit = wr_act_q && !wr_act;

  // Reset counter, capture and register writes
  always_comb begin
    next_master_reset_n_cnt = master_reset_n_cnt;
    next_boot = 1'b0;
    next_taddr = taddr;
    next_tpar = tpar;
    next_wr_act_q = wr_act;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_ctrl = ctrl;
    if (!s_master_reset_n_n) begin
      if (master_reset_n_cnt != MASTER_RESET_N_MIN_CYC) begin
        next_master_reset_n_cnt = master_reset_n_cnt + CNT_ONE;
      end
    end else begin
      next_master_reset_n_cnt = CNT_ZERO;
    end
    if (capture) begin
      next_taddr = s_taddr;
      next_tpar = s_par;
    end
    if (wr_act) begin
      next_wr_addr = s_addr;
      next_wr_data = s_data;
    end
    if (wr_commit && !soft_rst) begin
      unique case (wr_addr)
        REG_CTRL: begin
          next_ctrl[CTRL_PDP_BIT] = wr_data[CTRL_PDP_BIT];
          if (!s_lock) begin
            next_ctrl[CTRL_ROLE_BIT] = wr_data[CTRL_ROLE_BIT];
            next_ctrl[CTRL_MODE_LSB +: MODE_W] = wr_data[CTRL_MODE_LSB +: MODE_W];
          end
        end
        REG_TADDR: begin
          if (!s_lock && !capture) begin
            next_taddr = wr_data[TADDR_W-1:0];
            next_tpar = wr_data[TADDR_PAR_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (soft_rst) begin
      next_ctrl = CTRL_RESET;
      next_wr_act_q = 1'b0;
    end
  end

  // Registers of the configuration group
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      master_reset_n_cnt <= CNT_ZERO;
      boot <= 1'b1;
      taddr <= TADDR_RESET;
      tpar <= 1'b1;
      wr_act_q <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      ctrl <= CTRL_RESET;
    end else begin
      master_reset_n_cnt <= next_master_reset_n_cnt;
      boot <= next_boot;
      taddr <= next_taddr;
      tpar <= next_tpar;
      wr_act_q <= next_wr_act_q;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      ctrl <= next_ctrl;
    end
  end

  // Effective role, parity and mode decode
  logic role_eff, par_ok, pdp;
  assign role_eff = s_lock ? s_role : ctrl[CTRL_ROLE_BIT];
  assign par_ok = ^{taddr, tpar};
  assign pdp = ctrl[CTRL_PDP_BIT];

  // Own memory access sequencer state
  hmp_state_type state, next_state;
  logic [CNT_W-1:0] tmr, next_tmr;
  logic [CNT_W-1:0] words, next_words;
  logic [ADDR_W-1:0] maddr, next_maddr;
  logic mwrite, next_mwrite;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rvalid, next_rvalid, wnext, next_wnext;
  logic done, next_done, abort, next_abort;
  logic ovr_active;

  assign ovr_active = !s_ovr_n;

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_words = words;
    next_maddr = maddr;
    next_mwrite = mwrite;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_wnext = 1'b0;
    next_done = 1'b0;
    next_abort = 1'b0;
    unique case (state)
      HMP_IDLE: begin
        if (xfer_start_i && xfer_count_i != CNT_ZERO) begin
          next_state = HMP_REQ;
          next_maddr = xfer_addr_i;
          next_words = xfer_count_i;
          next_mwrite = xfer_write_i;
        end
      end
      HMP_REQ: begin
        if (s_grant) begin
          next_state = HMP_STRB;
          next_tmr = STROBE_CYC;
        end
      end
      HMP_STRB: begin
        if (tmr == CNT_ONE) begin
          next_state = HMP_GAP;
          next_tmr = GAP_CYC;
          next_words = words - CNT_ONE;
          if (mwrite) begin
            next_wnext = 1'b1;
          end else begin
            next_rdata = s_data;
            next_rvalid = 1'b1;
          end
        end else begin
          next_tmr = tmr - CNT_ONE;
        end
      end
      HMP_GAP: begin
        if (tmr == CNT_ONE) begin
          if (words == CNT_ZERO) begin
            next_state = HMP_IDLE;
            next_done = 1'b1;
          end else if (s_grant) begin
            next_state = HMP_STRB;
            next_tmr = STROBE_CYC;
            next_maddr = maddr + 16'h0001;
          end else begin
            next_state = HMP_REQ;
            next_maddr = maddr + 16'h0001;
          end
        end else begin
          next_tmr = tmr - CNT_ONE;
        end
      end
    endcase
    if (ovr_active || soft_rst) begin
      next_state = HMP_IDLE;
      next_rvalid = 1'b0;
      next_wnext = 1'b0;
      next_done = 1'b0;
      next_abort = (state != HMP_IDLE) && ovr_active;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= HMP_IDLE;
      tmr <= CNT_ZERO;
      words <= CNT_ZERO;
      maddr <= '0;
      mwrite <= 1'b0;
      rdata <= '0;
      rvalid <= 1'b0;
      wnext <= 1'b0;
      done <= 1'b0;
      abort <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      words <= next_words;
      maddr <= next_maddr;
      mwrite <= next_mwrite;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      wnext <= next_wnext;
      done <= next_done;
      abort <= next_abort;
    end
  end

  // Register read mux and data out register
  logic own_access, own_strobe, host_read;
  logic [DATA_W-1:0] dout, next_dout, rd_mux;

  assign own_access = (state == HMP_STRB) || (state == HMP_GAP);
  assign own_strobe = (state == HMP_STRB) && !soft_rst;
  assign host_read = !s_cs_n && !s_rd_n;

  always_comb begin
    rd_mux = '0;
    unique case (s_addr)
      REG_CTRL: rd_mux = ctrl;
      REG_STAT: begin
        rd_mux[STAT_ROLE_BIT] = role_eff;
        rd_mux[STAT_LOCK_BIT] = s_lock;
        rd_mux[STAT_OVR_BIT] = ovr_active;
        rd_mux[STAT_BUSY_BIT] = state != HMP_IDLE;
        rd_mux[STAT_PAR_BIT] = par_ok;
      end
      REG_TADDR: begin
        rd_mux[TADDR_W-1:0] = taddr;
        rd_mux[TADDR_PAR_BIT] = tpar;
        rd_mux[TADDR_OK_BIT] = par_ok;
      end
      default: rd_mux = '0;
    endcase
    next_dout = (own_access && mwrite) ? xfer_wdata_i : rd_mux;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dout <= '0;
    end else begin
      dout <= next_dout;
    end
  end

  // Pin drivers; buses float unless a transfer drives them
  assign addr_o = maddr;
  assign addr_oe_o = own_access && s_aen && !soft_rst;
  assign data_o = dout;
  assign data_oe_o = !soft_rst && ((host_read && !own_access) || (own_access && mwrite));

  // RAM select and strobes, own or passed through
  logic host_ram;
  assign host_ram = pdp && !own_access && !s_ram_select_in_n_n && !soft_rst;
  assign ram_select_out_n_o = !(own_access || host_ram);
  assign ram_read_strobe_n_o = !((own_strobe && !mwrite) || (host_ram && !s_rd_n));
  assign ram_write_strobe_n_o = !((own_strobe && mwrite) || (host_ram && !s_wr_n));
  assign dma_request_o = (state != HMP_IDLE) && !ovr_active;

  // Burst and status outputs
  assign xfer_wnext_o = wnext;
  assign xfer_rdata_o = rdata;
  assign xfer_rvalid_o = rvalid;
  assign xfer_done_o = done;
  assign xfer_abort_o = abort;
  assign xfer_busy_o = state != HMP_IDLE;
  assign role_bc_o = role_eff;
  assign op_mode_o = ctrl[CTRL_MODE_LSB +: MODE_W];
  assign pdp_mode_o = pdp;
  assign term_addr_o = taddr;
  assign term_parity_ok_o = par_ok;
  assign override_active_o = ovr_active;
  assign master_reset_active_o = soft_rst;
endmodule

//--- dv/hmp_chk_asserts.sv
`timescale 1ns/100ps
module hmp_chk (
  input wire logic sys_clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic cs_n_i, // Select
  input wire logic rd_n_i, // Read
  input wire logic addr_drive_enable_i, // Address enable
  input wire logic lock_i, // Lock
  input wire logic role_select_pin_i, // Role pin
  input wire logic external_override_n_i, // Override
  input wire logic dma_grant_i, // Grant
  input wire logic ram_select_in_n_i, // Host RAM select
  input wire logic data_oe_o, // Data drive
  input wire logic addr_oe_o, // Address drive
  input wire logic ram_select_out_n_o, // RAM select
  input wire logic ram_read_strobe_n_o, // RAM read
  input wire logic ram_write_strobe_n_o, // RAM write
  input wire logic dma_request_o, // Request
  input wire logic xfer_busy_o, // Busy
  input wire logic role_bc_o, // Role
  input wire logic pdp_mode_o, // Pass mode
  input wire logic master_reset_active_o // Master reset
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Either RAM strobe
  wire strb_n = ram_read_strobe_n_o & ram_write_strobe_n_o;

  a_data_float: assert property (((cs_n_i || rd_n_i) && !xfer_busy_o)[*4] |-> !data_oe_o)
    else $error("data bus driven without a read");
  a_addr_gate: assert property (!addr_drive_enable_i[*3] |-> !addr_oe_o)
    else $error("address driven without enable");
  a_addr_idle: assert property (!xfer_busy_o |-> !addr_oe_o)
    else $error("address driven while idle");
  a_grant_first: assert property ((!dma_grant_i && ram_select_in_n_i)[*4] |-> strb_n)
    else $error("strobe without grant");
  // Host pass-through strobes have their own timing
  a_strobe_len: assert property (disable iff (reset_i || !external_override_n_i || master_reset_active_o ||
    !ram_select_in_n_i) $fell(strb_n) |-> !strb_n[*8] ##1 !strb_n ##1 !strb_n ##1 strb_n)
    else $error("strobe width wrong");
  a_strobe_gap: assert property (disable iff (reset_i || !external_override_n_i || master_reset_active_o ||
    !ram_select_in_n_i) $rose(strb_n) |-> strb_n[*5])
    else $error("strobe gap too short");
  a_select_own: assert property (!strb_n |-> !ram_select_out_n_o)
    else $error("strobe without RAM select");
  a_pdp_pass: assert property ((pdp_mode_o && !ram_select_in_n_i)[*4] |-> !ram_select_out_n_o)
    else $error("host RAM select not passed");
  a_lock_role: assert property ((lock_i && $stable(role_select_pin_i))[*4] |-> role_bc_o == role_select_pin_i)
    else $error("locked role differs from pin");
  a_ovr_abort: assert property (!external_override_n_i[*4] |-> !dma_request_o && strb_n)
    else $error("activity under override");
  a_master_reset_n_float: assert property (master_reset_active_o |-> !data_oe_o && !addr_oe_o && strb_n)
    else $error("activity in master reset");
endmodule

bind hmp_host_memory_port hmp_chk u_chk (.sys_clk_i, .reset_i, .cs_n_i, .rd_n_i, .addr_drive_enable_i, .lock_i,
  .role_select_pin_i, .external_override_n_i, .dma_grant_i, .ram_select_in_n_i, .data_oe_o, .addr_oe_o,
  .ram_select_out_n_o, .ram_read_strobe_n_o, .ram_write_strobe_n_o, .dma_request_o, .xfer_busy_o, .role_bc_o,
  .pdp_mode_o, .master_reset_active_o);

//--- dv/hmp_ram_model.sv
`timescale 1ns/100ps
module hmp_ram_model #(
  parameter int LAT = 3
) (
  input wire logic clk_i, // Clock
  input wire logic sel_n_i, // Select, low
  input wire logic rd_n_i, // Read, low
  input wire logic wr_n_i, // Write, low
  input wire logic [15:0] addr_i, // Address
  input wire logic [15:0] data_i, // Data bus
  output logic [15:0] data_o, // Read word
  output logic oe_o, // Drives data bus
  output int n_rd_o, // Read pulses
  output int n_wr_o // Write pulses
);
  logic [15:0] mem [256];
  int age = 0;
  // Store written words, time each read
  always @(posedge clk_i) begin
    if (!sel_n_i && !wr_n_i) begin
      mem[addr_i[7:0]] <= data_i;
    end
    age <= (!sel_n_i && !rd_n_i) ? age + 1 : 0;
  end
  // Count strobe pulses
  initial begin
    n_rd_o = 0;
    n_wr_o = 0;
  end
  always @(negedge rd_n_i) n_rd_o++;
  always @(negedge wr_n_i) n_wr_o++;
  // Slow part shows a wrong word until access time passes
  assign oe_o = !sel_n_i && !rd_n_i;
  assign data_o = (age >= LAT) ? mem[addr_i[7:0]] : ~mem[addr_i[7:0]];
endmodule

//--- dv/tb_host_memory_port_pins.sv
`timescale 1ns/100ps
module tb_host_memory_port_pins;
  import hmp_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1, host_oe = 1'b0;
  logic addr_drive_enable_i = 1'b1, term_addr_parity_i = 1'b1, role_select_pin_i = 1'b0, lock_i = 1'b0;
  logic external_override_n_i = 1'b1, master_reset_n_i = 1'b1, ram_select_in_n_i = 1'b1, dma_grant_i = 1'b0;
  logic xfer_start_i = 1'b0, xfer_write_i = 1'b0, ram_oe;
  logic [3:0] host_a = 4'h0, addr_i;
  logic [4:0] term_addr_i = 5'h1f, term_addr_o;
  logic [7:0] xfer_count_i = 8'h00, op_mode_o;
  logic [15:0] xfer_addr_i = 16'h0000, host_d = 16'h0000, idle_d = 16'h0000, rd;
  logic [15:0] xfer_wdata_i, data_i, ram_q, addr_o, data_o, xfer_rdata_o;
  logic addr_oe_o, data_oe_o, ram_select_out_n_o, ram_read_strobe_n_o, ram_write_strobe_n_o, dma_request_o;
  logic xfer_wnext_o, xfer_rvalid_o, xfer_done_o, xfer_abort_o, xfer_busy_o, role_bc_o, pdp_mode_o;
  logic term_parity_ok_o, override_active_o, master_reset_active_o;
  logic [15:0] wq [4] = '{16'h1234, 16'hbeef, 16'h0f0f, 16'ha5a5};
  logic [15:0] rq [4];
  int n_fail = 0, tests_run = 0, n_rd, n_wr, wi = 0, ri = 0;
  // Shared pins: device drive wins, else RAM, else host, else changing junk
  assign addr_i = addr_oe_o ? addr_o[3:0] : host_a;
  assign data_i = data_oe_o ? data_o : ram_oe ? ram_q : host_oe ? host_d : idle_d;
  assign xfer_wdata_i = wq[wi[1:0]];

  hmp_host_memory_port DUT (.sys_clk_i, .reset_i, .addr_i, .addr_o, .addr_oe_o, .data_i, .data_o, .data_oe_o,
    .cs_n_i, .rd_n_i, .wr_n_i, .addr_drive_enable_i, .term_addr_i, .term_addr_parity_i, .role_select_pin_i,
    .lock_i, .external_override_n_i, .master_reset_n_i, .ram_select_in_n_i, .ram_select_out_n_o,
    .ram_read_strobe_n_o, .ram_write_strobe_n_o, .dma_grant_i, .dma_request_o, .xfer_start_i, .xfer_write_i,
    .xfer_addr_i, .xfer_count_i, .xfer_wdata_i, .xfer_wnext_o, .xfer_rdata_o, .xfer_rvalid_o, .xfer_done_o,
    .xfer_abort_o, .xfer_busy_o, .role_bc_o, .op_mode_o, .pdp_mode_o, .term_addr_o, .term_parity_ok_o,
    .override_active_o, .master_reset_active_o);
  hmp_ram_model RAM (.clk_i(sys_clk_i), .sel_n_i(ram_select_out_n_o), .rd_n_i(ram_read_strobe_n_o),
    .wr_n_i(ram_write_strobe_n_o), .addr_i(addr_o), .data_i(data_i), .data_o(ram_q), .oe_o(ram_oe),
    .n_rd_o(n_rd), .n_wr_o(n_wr));

  initial forever #2 sys_clk_i = ~sys_clk_i;
  // Grant follows request, burst words move on
  always @(negedge sys_clk_i) begin
    idle_d <= idle_d + 16'h1357;
    dma_grant_i <= dma_request_o;
    if (xfer_wnext_o) wi <= wi + 1;
    if (xfer_rvalid_o) begin
      rq[ri[1:0]] <= xfer_rdata_o;
      ri <= ri + 1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    host_a = a;
    host_d = d;
    host_oe = 1'b1;
    cs_n_i = 1'b0;
    wr_n_i = 1'b0;
    cyc(6);
    cs_n_i = 1'b1;
    wr_n_i = 1'b1;
    cyc(3);
    host_oe = 1'b0;
    cyc(3);
  endtask
  task automatic reg_rd(input logic [3:0] a);
    host_a = a;
    cs_n_i = 1'b0;
    rd_n_i = 1'b0;
    cyc(6);
    rd = data_i;
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
    cyc(4);
  endtask
  task automatic burst(input logic wr, input logic [7:0] n);
    xfer_write_i = wr;
    xfer_addr_i = 16'h0040;
    xfer_count_i = n;
    wi = 0;
    ri = 0;
    xfer_start_i = 1'b1;
    cyc(1);
    xfer_start_i = 1'b0;
    for (int i = 0; i < 300 && !xfer_done_o && !xfer_abort_o; i++) cyc(1);
  endtask
  task automatic t_mreset(input logic [4:0] ta, input logic par, input int len, input logic [15:0] exp);
    term_addr_i = ta;
    term_addr_parity_i = par;
    master_reset_n_i = 1'b0;
    cyc(len);
    chk(master_reset_active_o, len > 130);
    master_reset_n_i = 1'b1;
    cyc(5);
    reg_rd(REG_TADDR);
    chk(rd, exp);
    chk(term_parity_ok_o, exp[6]);
  endtask
  task automatic t_regs;
    reg_wr(REG_CTRL, 16'ha503);
    reg_rd(REG_CTRL);
    chk(rd, 16'ha503);
    chk(data_oe_o, 1'b0);
    chk({op_mode_o, 6'h00, pdp_mode_o, role_bc_o}, 16'ha503);
    reg_wr(REG_STAT, 16'hffee);
    reg_rd(REG_STAT);
    chk(rd, 16'h0011);
    reg_wr(4'h7, 16'hffff);
    reg_rd(4'h7);
    chk(rd, 16'h0000);
  endtask
  task automatic t_lock;
    lock_i = 1'b1;
    cyc(4);
    chk(role_bc_o, 1'b0);
    reg_wr(REG_CTRL, 16'h3c02);
    reg_wr(REG_TADDR, 16'h0001);
    reg_rd(REG_CTRL);
    chk(rd, 16'ha503);
    chk(term_addr_o, 5'h15);
    lock_i = 1'b0;
    cyc(4);
    chk(role_bc_o, 1'b1);
  endtask
  task automatic t_burst;
    burst(1'b1, 8'h03);
    chk(16'(n_wr), 16'h0003);
    chk(RAM.mem[8'h42], 16'h0f0f);
    addr_drive_enable_i = 1'b0;
    burst(1'b0, 8'h03);
    addr_drive_enable_i = 1'b1;
    chk(16'(n_rd), 16'h0003);
    for (int i = 0; i < 3; i++) chk(rq[i], wq[i]);
  endtask
  task automatic t_override;
    fork
      burst(1'b0, 8'h04);
      begin
        cyc(30);
        chk(addr_oe_o, 1'b1);
        chk(addr_o, 16'h0041);
        external_override_n_i = 1'b0;
      end
    join
    chk({xfer_abort_o, xfer_done_o, ram_read_strobe_n_o}, 16'h0005);
    chk(override_active_o, 1'b1);
    // Hold override a while so the idle check sees it
    cyc(4);
    chk(dma_request_o, 1'b0);
    external_override_n_i = 1'b1;
    cyc(4);
  endtask
  task automatic t_pdp;
    ram_select_in_n_i = 1'b0;
    cyc(4);
    chk(ram_select_out_n_o, 1'b0);
    // Host reads then writes the RAM through the device
    rd_n_i = 1'b0;
    cyc(4);
    chk({ram_select_out_n_o, ram_read_strobe_n_o}, 16'h0000);
    rd_n_i = 1'b1;
    wr_n_i = 1'b0;
    cyc(4);
    chk({ram_read_strobe_n_o, ram_write_strobe_n_o}, 16'h0002);
    wr_n_i = 1'b1;
    cyc(4);
    ram_select_in_n_i = 1'b1;
    cyc(4);
    chk(ram_select_out_n_o, 1'b1);
  endtask
  initial begin
    cyc(12);
    reset_i = 1'b0;
    cyc(5);
    chk(term_addr_o, 5'h1f);
    chk({addr_oe_o, data_oe_o}, 16'h0000);
    t_mreset(5'h0a, 1'b1, 135, 16'h006a);
    t_mreset(5'h0b, 1'b1, 135, 16'h002b);
    t_mreset(5'h15, 1'b0, 60, 16'h002b);
    t_mreset(5'h15, 1'b0, 135, 16'h0055);
    t_regs;
    t_lock;
    t_burst;
    t_override;
    t_pdp;
    end_sim;
  end
  // Watchdog
  initial begin
    #40000;
    n_fail++;
    end_sim;
  end
endmodule
